// [scf_strap_loader.sv]
// Purpose: Samples the reset straps, fixes the port-5 and management modes, runs the LED pins.
// Assumes: Straps are steady while i_reset_n is low; i_mgmt_clk may stop between frames.
// Notes:   Strap pins are undriven until the latch; afterwards they become LED outputs.
`timescale 1ns/10ps

module scf_strap_loader import scf_pkg::*; (
  // Core clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  // Strap and LED pins
  input  wire logic [STRAP_N-1:0]            i_strap_pin,
  output logic      [STRAP_N-1:0]            o_strap_pin,
  output logic      [STRAP_N-1:0]            o_strap_pin_oe,
  input  wire logic [STRAP_N*LED_SRC_N-1:0]  i_led_src,
  input  wire logic [LED_MODE_W-1:0]         i_led_mode,
  // Control bits
  input  wire logic                          i_rmii_clk_ovr_en,
  input  wire logic                          i_rmii_clk_ovr_int,
  input  wire logic                          i_speed_ovr_en,
  input  wire logic                          i_speed_ovr_gig,
  // Management pins
  input  wire logic                          i_mgmt_clk,
  input  wire logic                          i_mgmt_chip_select_n,
  input  wire logic                          i_mgmt_data,
  output logic                               o_mgmt_data,
  output logic                               o_mgmt_data_oe,
  input  wire logic                          i_serial_out_pin,
  output logic                               o_serial_out_pin,
  output logic                               o_serial_out_pin_oe,
  // Management data from the switch core
  input  wire logic                          i_spi_tx_bit,
  input  wire logic                          i_mdio_tx_bit,
  input  wire logic                          i_mdio_tx_en,
  // Configuration results
  output logic                               o_cfg_valid,
  output logic      [1:0]                    o_port5_if,
  output logic                               o_port5_if_rsvd,
  output logic                               o_mii_mac_role,
  output logic                               o_rmii_clock_mode,
  output logic                               o_port5_rx_clock_drive,
  output logic                               o_ext_refclk_needed,
  output logic                               o_ref_clock_out_en,
  output logic                               o_pll_use_tx_clock,
  output logic                               o_rgmii_gig,
  output logic                               o_mdio_mode,
  // Management receive events
  output logic                               o_spi_start,
  output logic      [BYTE_W-1:0]             o_mgmt_byte,
  output logic                               o_mgmt_byte_vld
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [STRAP_N-1:0] strap_s1_r;
  logic [STRAP_N-1:0] strap_s2_r;
  logic               sout_s1_r;
  logic               sout_s2_r;
  logic               cs_s1_r;
  logic               cs_s2_r;
  logic               cs_s3_r;
  logic               tgl_s1_r;
  logic               tgl_s2_r;
  logic               tgl_s3_r;
  logic [BYTE_W-1:0]  rx_byte;
  logic               rx_tgl;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_s1_r <= STRAP_RST;
      strap_s2_r <= STRAP_RST;
      sout_s1_r  <= 1'b0;
      sout_s2_r  <= 1'b0;
      cs_s1_r    <= 1'b1;
      cs_s2_r    <= 1'b1;
      cs_s3_r    <= 1'b1;
      tgl_s1_r   <= 1'b0;
      tgl_s2_r   <= 1'b0;
      tgl_s3_r   <= 1'b0;
    end else begin
      strap_s1_r <= i_strap_pin;
      strap_s2_r <= strap_s1_r;
      sout_s1_r  <= i_serial_out_pin;
      sout_s2_r  <= sout_s1_r;
      cs_s1_r    <= i_mgmt_chip_select_n;
      cs_s2_r    <= cs_s1_r;
      cs_s3_r    <= cs_s2_r;
      tgl_s1_r   <= rx_tgl;
      tgl_s2_r   <= tgl_s1_r;
      tgl_s3_r   <= tgl_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture sequence
  // ----------------------------------------------------------------
  scf_state_t            state_r;
  scf_state_t            state_nxt;
  logic [SETTLE_W-1:0]   settle_r;
  logic [SETTLE_W-1:0]   settle_nxt;
  logic [STRAP_N-1:0]    strap_r;
  logic [STRAP_N-1:0]    strap_nxt;
  logic                  sout_r;
  logic                  sout_nxt;

  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    strap_nxt  = strap_r;
    sout_nxt   = sout_r;
    case (state_r)
      ST_SETTLE: begin
        settle_nxt = settle_r + 3'h1;
        if (settle_r == SETTLE_LAST) begin
          state_nxt = ST_LATCH;
        end
      end
      ST_LATCH: begin
        strap_nxt = strap_s2_r; // RQ15
        sout_nxt  = sout_s2_r; // RQ15
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        state_nxt = ST_RUN; // RQ17
      end
      default: begin
        state_nxt = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin // RQ13
      state_r  <= ST_SETTLE;
      settle_r <= SETTLE_ZERO;
      strap_r  <= STRAP_RST;
      sout_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      strap_r  <= strap_nxt;
      sout_r   <= sout_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic                 run;
  logic [1:0]           p5_if;
  logic                 is_mii;
  logic                 is_rmii;
  logic                 clk_int;
  logic                 mdio_mode;
  logic                 cfg_valid_nxt;
  logic                 mii_mac_nxt;
  logic                 rmii_clk_nxt;
  logic                 rx_drive_nxt;
  logic                 ext_ref_nxt;
  logic                 refclk_nxt;
  logic                 pll_tx_nxt;
  logic                 gig_nxt;

  assign run       = (state_r == ST_RUN);
  assign p5_if     = {strap_r[STRAP_IF_HI], strap_r[STRAP_IF_LO]}; // RQ16
  assign is_mii    = (p5_if == P5_IF_MII);
  assign is_rmii   = (p5_if == P5_IF_RMII);
  assign mdio_mode = sout_r; // RQ8

  always_comb begin
    clk_int       = i_rmii_clk_ovr_en ? i_rmii_clk_ovr_int : strap_r[STRAP_ROLE]; // RQ4
    cfg_valid_nxt = run;
    mii_mac_nxt   = run & is_mii & strap_r[STRAP_ROLE]; // RQ1
    rmii_clk_nxt  = run & is_rmii & clk_int;
    rx_drive_nxt  = run & is_rmii & clk_int; // RQ2
    ext_ref_nxt   = run & is_rmii & ~clk_int; // RQ3
    refclk_nxt    = run & strap_r[STRAP_REFCLK]; // RQ5
    pll_tx_nxt    = run & is_rmii & ~clk_int & ~strap_r[STRAP_PLL]; // RQ6
    gig_nxt       = run & (i_speed_ovr_en ? i_speed_ovr_gig : strap_r[STRAP_SPEED]); // RQ7
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cfg_valid            <= 1'b0;
      o_port5_if             <= P5_IF_RGMII;
      o_port5_if_rsvd        <= 1'b0;
      o_mii_mac_role         <= 1'b0;
      o_rmii_clock_mode      <= 1'b0;
      o_port5_rx_clock_drive <= 1'b0;
      o_ext_refclk_needed    <= 1'b0;
      o_ref_clock_out_en     <= 1'b0;
      o_pll_use_tx_clock     <= 1'b0;
      o_rgmii_gig            <= 1'b0;
      o_mdio_mode            <= 1'b0;
    end else begin
      o_cfg_valid            <= cfg_valid_nxt;
      o_port5_if             <= run ? p5_if : P5_IF_RGMII;
      o_port5_if_rsvd        <= run & (p5_if == P5_IF_RSVD);
      o_mii_mac_role         <= mii_mac_nxt;
      o_rmii_clock_mode      <= rmii_clk_nxt;
      o_port5_rx_clock_drive <= rx_drive_nxt;
      o_ext_refclk_needed    <= ext_ref_nxt;
      o_ref_clock_out_en     <= refclk_nxt;
      o_pll_use_tx_clock     <= pll_tx_nxt;
      o_rgmii_gig            <= gig_nxt;
      o_mdio_mode            <= run & mdio_mode;
    end
  end

  // ----------------------------------------------------------------
  // LED outputs on the strap pins
  // ----------------------------------------------------------------
  logic [STRAP_N-1:0] led_nxt;

  genvar g;
  generate
    for (g = 0; g < STRAP_N; g++) begin : g_led
      assign led_nxt[g] = i_led_src[g*LED_SRC_N + int'(i_led_mode)]; // RQ14
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_strap_pin    <= STRAP_RST;
      o_strap_pin_oe <= STRAP_RST;
    end else begin
      o_strap_pin    <= run ? led_nxt : STRAP_RST; // RQ14
      o_strap_pin_oe <= {STRAP_N{run}}; // RQ17
    end
  end

  // ----------------------------------------------------------------
  // Management pin drivers
  // ----------------------------------------------------------------
  logic spi_sel;
  logic sout_oe_nxt;
  logic mdio_oe_nxt;

  assign spi_sel     = run & ~mdio_mode & ~cs_s2_r;
  assign sout_oe_nxt = spi_sel; // RQ11
  assign mdio_oe_nxt = run & mdio_mode & i_mdio_tx_en; // RQ10

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_out_pin    <= 1'b0;
      o_serial_out_pin_oe <= 1'b0;
      o_mgmt_data         <= 1'b0;
      o_mgmt_data_oe      <= 1'b0;
    end else begin
      o_serial_out_pin    <= sout_oe_nxt & i_spi_tx_bit;
      o_serial_out_pin_oe <= sout_oe_nxt;
      o_mgmt_data         <= mdio_oe_nxt & i_mdio_tx_bit;
      o_mgmt_data_oe      <= mdio_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Management receive path
  // ----------------------------------------------------------------
  logic              start_nxt;
  logic              byte_ev;

  scf_mgmt_rx u_rx (
    .i_mgmt_clk (i_mgmt_clk),
    .i_reset_n  (i_reset_n),
    .i_cs_n     (i_mgmt_chip_select_n),
    .i_data     (i_mgmt_data),
    .i_spi_mode (run & ~mdio_mode),
    .o_byte     (rx_byte),
    .o_byte_tgl (rx_tgl)
  );

  assign start_nxt = run & ~mdio_mode & cs_s3_r & ~cs_s2_r; // RQ12
  assign byte_ev   = tgl_s3_r ^ tgl_s2_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_spi_start     <= 1'b0;
      o_mgmt_byte     <= BYTE_ZERO;
      o_mgmt_byte_vld <= 1'b0;
    end else begin
      o_spi_start     <= start_nxt;
      o_mgmt_byte     <= byte_ev ? rx_byte : o_mgmt_byte;
      o_mgmt_byte_vld <= byte_ev;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  mii_role_map_a: assert property ( // RQ1
    o_cfg_valid && o_port5_if == P5_IF_MII |-> o_mii_mac_role == strap_r[STRAP_ROLE])
    else $error("MII role does not follow the role strap.");
  rx_clock_drive_a: assert property ( // RQ2
    o_port5_rx_clock_drive |-> o_port5_if == P5_IF_RMII && o_rmii_clock_mode)
    else $error("Receive clock driven outside RMII clock mode.");
  ext_ref_need_a: assert property ( // RQ3
    o_cfg_valid && o_port5_if == P5_IF_RMII |-> o_ext_refclk_needed != o_rmii_clock_mode)
    else $error("RMII normal mode and clock mode disagree.");
  clk_ovr_follow_a: assert property ( // RQ4
    run && is_rmii && i_rmii_clk_ovr_en |=> o_rmii_clock_mode == $past(i_rmii_clk_ovr_int))
    else $error("RMII clock override ignored.");
  refclk_strap_a: assert property ( // RQ5
    o_cfg_valid |-> o_ref_clock_out_en == strap_r[STRAP_REFCLK])
    else $error("Reference clock enable differs from strap.");
  pll_source_a: assert property ( // RQ6
    o_pll_use_tx_clock |-> o_ext_refclk_needed && !strap_r[STRAP_PLL])
    else $error("PLL uses transmit clock without cause.");
  speed_strap_a: assert property ( // RQ7
    run && !i_speed_ovr_en |=> o_rgmii_gig == strap_r[STRAP_SPEED])
    else $error("RGMII speed differs from strap.");
  sout_hiz_a: assert property ( // RQ11
    cs_s2_r |=> !o_serial_out_pin_oe)
    else $error("Serial output driven while deselected.");
  spi_start_a: assert property ( // RQ12
    $fell(cs_s2_r) && run && !mdio_mode |=> o_spi_start ##1 !o_spi_start)
    else $error("Transfer start not flagged for one cycle.");
  strap_hold_a: assert property ( // RQ17
    o_cfg_valid |=> $stable(strap_r) && $stable(sout_r))
    else $error("Latched straps changed after capture.");
  sample_time_a: assert property ( // RQ15
    $rose(o_cfg_valid) |-> $past(state_r, 2) == ST_LATCH)
    else $error("Configuration valid at wrong time.");
  led_drive_a: assert property ( // RQ14
    !run |=> o_strap_pin_oe == STRAP_RST)
    else $error("Strap pins driven before sampling.");
  mdio_data_a: assert property ( // RQ10
    o_mgmt_data_oe |-> o_mdio_mode)
    else $error("Data pin driven outside MDC/MDIO mode.");

  rmii_clock_c: cover property (o_port5_rx_clock_drive);
  rmii_normal_c: cover property (o_pll_use_tx_clock);
  spi_byte_c: cover property (o_spi_start ##[1:300] o_mgmt_byte_vld);
  mdio_drive_c: cover property (o_mgmt_data_oe);

endmodule // scf_strap_loader

// [scf_pkg.sv]
// Purpose: Constants shared by the strap configuration loader and its management receiver.
// Assumes: Core clock of 20 MHz; straps settle while the hardware reset is held.
// Notes:   Strap pin order inside the strap vector is fixed by the index constants below.
//
// Function
// (RQ1) In MII mode on port 5 the role strap high gives the MAC role and low gives the PHY role.
// (RQ2) In RMII mode with the role strap high the device drives a 50 MHz reference clock on the port-5 receive clock pin from the 25 MHz oscillator.
// (RQ3) In RMII mode with the role strap low the device runs in normal mode and the far party supplies a 50 MHz clock on the port-5 reference clock input.
// (RQ4) The internal or external RMII clock choice follows either the strap or control bit 7 of register 86.
// (RQ5) The 25 MHz reference clock output is enabled when its strap is high, the default, and disabled when it is low.
// (RQ6) The PLL source strap high keeps the crystal clock as PLL source in RMII normal mode, and low uses the port-5 transmit clock.
// (RQ7) The RGMII speed strap high gives 1 Gbps, the default, and low gives 10/100 Mbps, and registers may also set the speed.
// (RQ8) The serial-output strap low selects SPI client management and high selects MDC/MDIO, and the board fits a pull resistor on it.
// (RQ9) The host drives the shared management clock at no more than 25 MHz in either mode.
// (RQ10) The shared data pin is the serial data input in SPI mode and the bidirectional data line in MDC/MDIO mode.
// (RQ11) While chip select is high the device is deselected and its SPI serial output is high impedance.
// (RQ12) A falling chip select starts an SPI transfer.
// (RQ13) Driving the active-low hardware reset low resets the device.
// (RQ14) After sampling each strap pin acts as a LED output whose indication is chosen by bits 5 to 4 of global register 11.
// (RQ15) All strap levels are sampled during reset and fix the configured modes; the loader samples them after reset release and a 3-cycle settle.
// (RQ16) The two-bit interface strap selects 00 MII, 01 RMII, 10 reserved and 11 RGMII, the default.
// (RQ17) Strap values are latched on reset release and stay stable until the next reset; the loader latches them after the 3-cycle settle.

package scf_pkg;

  // ----------------------------------------------------------------
  // Port-5 interface encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] P5_IF_MII   = 2'h0;
  localparam logic [1:0] P5_IF_RMII  = 2'h1;
  localparam logic [1:0] P5_IF_RSVD  = 2'h2;
  localparam logic [1:0] P5_IF_RGMII = 2'h3;

  // ----------------------------------------------------------------
  // Strap vector layout
  // ----------------------------------------------------------------
  localparam int STRAP_N        = 6;
  localparam int STRAP_IF_LO    = 0;
  localparam int STRAP_IF_HI    = 1;
  localparam int STRAP_ROLE     = 2;
  localparam int STRAP_REFCLK   = 3;
  localparam int STRAP_PLL      = 4;
  localparam int STRAP_SPEED    = 5;
  localparam logic [STRAP_N-1:0] STRAP_RST = 6'h00;

  // ----------------------------------------------------------------
  // LED indication selection
  // ----------------------------------------------------------------
  localparam int LED_MODE_W = 2;
  localparam int LED_SRC_N  = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int STRAP_SETTLE_NS  = 150;
  localparam int SETTLE_CYC       = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W         = 3;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Management receiver
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Loader states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SETTLE = 3'h1,
    ST_LATCH  = 3'h2,
    ST_RUN    = 3'h4
  } scf_state_t;

endpackage

// [scf_mgmt_rx.sv]
// Purpose: Shifts SPI serial data in on the host's management clock and hands bytes over.
// Assumes: Chip select high ends a frame and clears the bit position asynchronously.
// Notes:   Each byte completed in SPI mode flips a toggle that the core domain synchronises.
`timescale 1ns/10ps

module scf_mgmt_rx import scf_pkg::*; (
  // Link clock and resets
  input  wire logic              i_mgmt_clk,
  input  wire logic              i_reset_n,
  // Management pins
  input  wire logic              i_cs_n,
  input  wire logic              i_data,
  // Static configuration from the core
  input  wire logic              i_spi_mode,
  // Hand-over to the core
  output logic [BYTE_W-1:0]      o_byte,
  output logic                   o_byte_tgl
);

  logic                 frame_rst_n;
  logic                 mode_s1_r;
  logic                 mode_s2_r;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BIT_CNT_W-1:0] bit_cnt_nxt;
  logic [BYTE_W-1:0]    shift_r;
  logic [BYTE_W-1:0]    shift_nxt;
  logic [BYTE_W-1:0]    byte_r;
  logic [BYTE_W-1:0]    byte_nxt;
  logic                 tgl_r;
  logic                 tgl_nxt;

  // A deselected port forgets any partial byte.
  assign frame_rst_n = i_reset_n & ~i_cs_n; // RQ11

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  // The link clock stops between frames, so the mode synchroniser only settles during a frame.
  // The shifter therefore runs on every rising link edge and the mode gates only the hand-over.
  always_comb begin
    bit_cnt_nxt = bit_cnt_r + 3'h1;
    shift_nxt   = {shift_r[BYTE_W-2:0], i_data}; // RQ10
  end

  always_ff @(posedge i_mgmt_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_r <= BIT_ZERO;
      shift_r   <= BYTE_ZERO;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Byte hand-over
  // ----------------------------------------------------------------
  always_comb begin
    byte_nxt = byte_r;
    tgl_nxt  = tgl_r;
    if (mode_s2_r && !i_cs_n && bit_cnt_r == BIT_LAST) begin
      byte_nxt = {shift_r[BYTE_W-2:0], i_data};
      tgl_nxt  = ~tgl_r;
    end
  end

  always_ff @(posedge i_mgmt_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
      byte_r    <= BYTE_ZERO;
      tgl_r     <= 1'b0;
    end else begin
      mode_s1_r <= i_spi_mode;
      mode_s2_r <= mode_s1_r;
      byte_r    <= byte_nxt;
      tgl_r     <= tgl_nxt;
    end
  end

  assign o_byte     = byte_r;
  assign o_byte_tgl = tgl_r;

endmodule // scf_mgmt_rx

// [scf_host_model.sv]
// Purpose: Host controller on the shared management pins, SPI client traffic only.
// Assumes: Management clock of 48 ns period, running only inside a frame.
// Notes:   Idle chip select and data rest high, as their internal pull-ups would leave them; the clock rests low.
`timescale 1ns/10ps

module scf_host_model (
  // Management pins
  output logic o_mgmt_clk,
  output logic o_cs_n,
  output logic o_data
);
  initial begin
    o_mgmt_clk = 1'b0;
    o_cs_n     = 1'b1;
    o_data     = 1'b1;
  end

  // ----------------------------------------------------------------
  // One byte per frame, most significant bit first
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b);
    o_cs_n = 1'b0;
    #24;
    for (int i = 7; i >= 0; i--) begin
      o_data = b[i];
      #24 o_mgmt_clk = 1'b1;
      #24 o_mgmt_clk = 1'b0;
    end
    o_data = 1'b1;
    #48 o_cs_n = 1'b1;
  endtask
endmodule // scf_host_model

// [tb_strap_config_and_host_port_select.sv]
// Purpose: Checks strap capture, mode outputs, LED pins and SPI receive of the loader.
// Assumes: Core-side inputs change on the falling core clock edge; the host model moves the management pins in its own 24 ns steps.
// Notes:   Each strap set gets its own reset; the last set leaves SPI mode on.
`timescale 1ns/10ps

module tb_strap_config_and_host_port_select import scf_pkg::*;;
  logic        clk = 0, rst_n = 0, ser_strap = 0, tx_en = 0;
  logic        ovr_en = 0, ovr_int = 0, spd_en = 0, spd_gig = 0;
  logic [5:0]  strap = 0, pin_o, pin_oe, s, e;
  logic [23:0] led_src = 0;
  logic [1:0]  led_mode = 0, p5if, ic;
  logic        so, so_oe, md_o, md_oe, vld, start, rsvd, mac, rmiic, rxdrv;
  logic        ext, refen, pllt, gig, mdio, cfgv, m, hclk, hcs, hd;
  logic [7:0]  mbyte, got;
  logic [6:0]  tbl [8] = '{7'h44, 7'h08, 7'h45, 7'h01, 7'h59, 7'h02, 7'h43, 7'h2b};
  int          err_total = 0, n_tests = 0, n_st;
  wire  [5:0]  strap_w;

  always #25 clk = ~clk;
  for (genvar g = 0; g < 6; g++) begin : g_pin
    assign strap_w[g] = pin_oe[g] ? pin_o[g] : strap[g];
  end

  scf_host_model i_host (.o_mgmt_clk(hclk), .o_cs_n(hcs), .o_data(hd));

  scf_strap_loader i_dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_strap_pin(strap_w), .o_strap_pin(pin_o),
    .o_strap_pin_oe(pin_oe), .i_led_src(led_src), .i_led_mode(led_mode),
    .i_rmii_clk_ovr_en(ovr_en), .i_rmii_clk_ovr_int(ovr_int), .i_speed_ovr_en(spd_en),
    .i_speed_ovr_gig(spd_gig), .i_mgmt_clk(hclk), .i_mgmt_chip_select_n(hcs),
    .i_mgmt_data(md_oe ? md_o : hd), .o_mgmt_data(md_o), .o_mgmt_data_oe(md_oe),
    .i_serial_out_pin(so_oe ? so : ser_strap), .o_serial_out_pin(so),
    .o_serial_out_pin_oe(so_oe), .i_spi_tx_bit(1'b1), .i_mdio_tx_bit(1'b1),
    .i_mdio_tx_en(tx_en), .o_cfg_valid(cfgv), .o_port5_if(p5if), .o_port5_if_rsvd(rsvd),
    .o_mii_mac_role(mac), .o_rmii_clock_mode(rmiic), .o_port5_rx_clock_drive(rxdrv),
    .o_ext_refclk_needed(ext), .o_ref_clock_out_en(refen), .o_pll_use_tx_clock(pllt),
    .o_rgmii_gig(gig), .o_mdio_mode(mdio), .o_spi_start(start), .o_mgmt_byte(mbyte),
    .o_mgmt_byte_vld(vld)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_reset(input logic [5:0] st, input logic so_st);
    int k;
    rst_n = 1'b0;
    strap = st;
    ser_strap = so_st;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 20 && cfgv !== 1'b1; k++) @(negedge clk);
    if (cfgv !== 1'b1) begin
      err_total++;
      print_verdict;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    @(negedge clk);
    for (int c = 0; c < 8; c++) begin
      s = tbl[c][5:0];
      m = tbl[c][6];
      ic = s[1:0];
      do_reset(s, m);
      check({p5if, rsvd, mac}, {ic, ic == P5_IF_RSVD, ic == P5_IF_MII && s[2]});
      check({rmiic, rxdrv}, {2{ic == P5_IF_RMII && s[2]}});
      check(ext, ic == P5_IF_RMII && !s[2]);
      check(refen, s[3]);
      check(pllt, ic == P5_IF_RMII && !s[2] && !s[4]);
      check(mdio, m);
      if (ic == P5_IF_RGMII) check(gig, s[5]);
      ovr_en = 1'b1;
      ovr_int = !s[2];
      spd_en = 1'b1;
      spd_gig = !s[5];
      tx_en = 1'b1;
      repeat (2) @(negedge clk);
      check(rmiic, ic == P5_IF_RMII && !s[2]);
      if (ic == P5_IF_RGMII) check(gig, !s[5]);
      check({md_oe, md_o}, {m, m});
      ovr_en = 1'b0;
      spd_en = 1'b0;
      tx_en = m;
      @(negedge clk);
    end
    for (int md = 0; md < 4; md++) begin
      led_mode = md[1:0];
      led_src = 24'h9c63a5 << md;
      repeat (2) @(negedge clk);
      for (int g = 0; g < 6; g++) e[g] = led_src[g*4+md];
      check(pin_o, e);
      check(pin_oe, 6'h3f);
    end
    strap = ~strap;
    ser_strap = ~ser_strap;
    repeat (3) @(negedge clk);
    check({p5if, refen, gig, mdio}, {s[1:0], s[3], s[5], m});
    tx_en = 1'b1;
    check(so_oe, 1'b0);
    n_st = 0;
    got = 8'h00;
    fork
      i_host.send_byte(8'ha6);
      for (int k = 0; k < 40; k++) begin
        @(negedge clk);
        if (start === 1'b1) n_st++;
        if (vld === 1'b1) got = mbyte;
        if (k == 6) check({so_oe, so}, 2'b11);
      end
    join
    check(n_st, 1);
    check(got, 8'ha6);
    check({so_oe, md_oe}, 2'b00);
    rst_n = 1'b0;
    @(negedge clk);
    check({cfgv, pin_oe, mdio}, 8'h00);
    check(p5if, P5_IF_RGMII);
    print_verdict;
  end
endmodule // tb_strap_config_and_host_port_select
